// [test/rqm_ref_mon.sv]
`timescale 1ns/1ps
module rqm_ref_mon (
  input wire logic sys_clk_in,
  input wire logic [2:0] sc_fail_in,
  input wire logic [2:0] cf_fail_in,
  input wire logic [2:0] pf_fail_in,
  output logic [2:0] single_cycle_check_out,
  output logic [2:0] coarse_freq_check_out,
  output logic [2:0] precise_freq_check_out
);
  // Verdicts follow the commanded fault at the next rising edge; sampling
  // on the bench's own drive edge would race its blocking assignments
  always @(posedge sys_clk_in) begin
    single_cycle_check_out <= sc_fail_in;
    coarse_freq_check_out <= cf_fail_in;
    precise_freq_check_out <= pf_fail_in;
  end
endmodule // rqm_ref_mon

// [test/tb.sv]
`timescale 1ns/1ps
module tb;
  import rqm_pkg::*;
  localparam int TC = 4;
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic ref_switch_in = 1'b0;
  logic [2:0] sc = 3'h0, cf = 3'h0, pf = 3'h0, scc, cfc, pfc, disq;
  logic [7:0] rdata;
  logic [32:0] lim;
  logic sel, bo, ra, irq;
  int num_errors = 0;
  int checks = 0;
  always #12.5 sys_clk_in = ~sys_clk_in;
  rqm_ref_mon i_rqm_ref_mon (.sys_clk_in(sys_clk_in), .sc_fail_in(sc),
    .cf_fail_in(cf), .pf_fail_in(pf), .single_cycle_check_out(scc),
    .coarse_freq_check_out(cfc), .precise_freq_check_out(pfc));
  rqm_ref_qual #(.NUM_REFS(3), .TICK_CYCLES(TC)) i_rqm_ref_qual (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .single_cycle_check_in(scc), .coarse_freq_check_in(cfc),
    .precise_freq_check_in(pfc), .ref_switch_in(ref_switch_in),
    .reg_rdata_out(rdata), .ref_disq_out(disq), .range_limit_out(lim),
    .phase_realign_select_out(sel), .phase_buildout_out(bo),
    .phase_realign_out(ra), .irq_out(irq));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge sys_clk_in);
    reg_wr_in = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk_in);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge sys_clk_in);
    reg_rd_in = 1'b0;
    d = rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask
  // Bounded wait on one disqualify flag; n returns cycles spent
  task automatic wait_dq(input int r, input logic v, input int lm,
                         output int n);
    n = 0;
    while (disq[r] !== v) begin
      @(negedge sys_clk_in);
      n++;
      if (n > lm) begin
        num_errors++;
        $display("Error at %0t: seen %h expected %h", $time, disq[r], v);
        final_report();
      end
    end
  endtask
  task automatic set_fail(input int r, input int m, input logic v);
    if (m == 0)
      sc[r] = v;
    else if (m == 1)
      cf[r] = v;
    else
      pf[r] = v;
  endtask
  function automatic logic [10:0] tenth(input logic [2:0] c);
    logic [10:0] t [8] = '{120, 520, 1300, 830, 180, 320, 475, 675};
    return t[c];
  endfunction
  function automatic int drop_t(input int c);
    int t [9] = '{1, 1, 2, 10, 20, 100, 200, 1000, 2000};
    return t[c];
  endfunction
  function automatic int mult(input int c);
    int t [4] = '{2, 4, 16, 32};
    return t[c];
  endfunction
  // Full soak cycle on one reference: fail until dropped, clean until back
  task automatic soak(input int r, input int m, input int d, input int k);
    int n;
    set_fail(r, m, 1'b1);
    wait_dq(r, 1'b1, (drop_t(d) + 2) * TC + 8, n);
    check(n >= (drop_t(d) - 1) * TC, 1'b1);
    set_fail(r, m, 1'b0);
    wait_dq(r, 1'b0, (drop_t(d) * mult(k) + 2) * TC + 8, n);
    check(n >= (drop_t(d) * mult(k) - 1) * TC, 1'b1);
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] d;
    logic [2:0] a, b, c;
    int n;
    logic [7:0] ad [8] = '{8'h16, 8'h17, 8'h1a, 8'h1c, 8'h1d, 8'h0c, 8'h0d,
                           8'h20};
    logic [7:0] rv [8] = '{8'h33, 8'h33, 8'hff, 8'h15, 8'h7a, 8'hff, 8'hff,
                           8'h00};
    void'($urandom(32'hbebd7b79));
    repeat (20) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    sys_rst_in = 1'b0;
    check(sel, 1'b0);
    for (int i = 0; i < 8; i++) begin
      rd(ad[i], d);
      check(d, rv[i]);
    end
    // Reserved bits refuse a write and keep their reset value
    wr(8'h16, 8'hff);
    rd(8'h16, d);
    check(d, 8'h77);
    wr(8'h17, 8'hff);
    rd(8'h17, d);
    check(d, 8'h37);
    for (int i = 0; i < 12; i++) begin
      a = (i < 8) ? i[2:0] : 3'($urandom);
      b = (i < 8) ? ~i[2:0] : 3'($urandom);
      c = 3'($urandom);
      wr(8'h16, {1'b0, b, 1'b0, a});
      wr(8'h17, {5'h06, c});
      cyc(2);
      check(lim, {tenth(c), tenth(b), tenth(a)});
      rd(8'h16, d);
      check(d, {1'b0, b, 1'b0, a});
    end
    for (int k = 0; k < 2; k++) begin
      wr(8'h1d, {7'h3d, k[0]});
      cyc(1);
      check(sel, k[0]);
      ref_switch_in = 1'b1;
      cyc(1);
      ref_switch_in = 1'b0;
      check({bo, ra}, {~k[0], k[0]});
      cyc(1);
      check({bo, ra}, 2'b00);
    end
    for (int i = 0; i < 9; i++) begin
      wr(8'h1c, {4'h0, 4'(i)});
      soak(i % 3, i % 2, i, 0);
    end
    for (int k = 1; k < 4; k++) begin
      wr(8'h1c, {2'b00, 2'(k), 4'h1});
      set_fail(k - 1, 0, 1'b1);
      wait_dq(k - 1, 1'b1, 3 * TC + 8, n);
      rd(8'h0e, d);
      check(d, 8'h01 << (k - 1));
      set_fail(k - 1, 0, 1'b0);
      soak(k - 1, 1, 1, k);
    end
    wr(8'h1c, 8'h02);
    for (int r = 0; r < 3; r++) begin
      for (int m = 0; m < 2; m++) begin
        wr(8'h1a, ~(8'h01 << (2 * r + m)));
        set_fail(r, m, 1'b1);
        cyc(10 * TC);
        check(disq[r], 1'b0);
        set_fail(r, m, 1'b0);
        soak(r, 1 - m, 2, 0);
      end
    end
    wr(8'h1a, 8'hff);
    wr(8'h1c, 8'h07);
    for (int r = 0; r < 3; r++) begin
      for (int m = 0; m < 3; m++) begin
        a = (r == 2) ? 3'h0 : 3'(4 * r);
        set_fail(r, m, 1'b1);
        cyc(3);
        check(irq, 1'b1);
        wr((r == 2) ? 8'h0d : 8'h0c, ~(8'h01 << (a + (m == 2 ? 3 : m))));
        cyc(3);
        check(irq, 1'b0);
        wr((r == 2) ? 8'h0d : 8'h0c, 8'hff);
        set_fail(r, m, 1'b0);
        cyc(3);
        check(irq, 1'b0);
      end
    end
    // Only the soak indication of reference A may interrupt
    wr(8'h0c, 8'h04);
    wr(8'h0d, 8'hf0);
    wr(8'h1c, 8'h01);
    set_fail(0, 0, 1'b1);
    wait_dq(0, 1'b1, 3 * TC + 8, n);
    cyc(2);
    check(irq, 1'b1);
    wr(8'h0c, 8'h00);
    cyc(3);
    check(irq, 1'b0);
    set_fail(0, 0, 1'b0);
    wait_dq(0, 1'b0, 4 * TC + 8, n);
    wr(8'h0c, 8'hff);
    wr(8'h0d, 8'hff);
    cyc(3);
    check(irq, 1'b0);
    final_report();
  end
endmodule // tb

// [verilog/rqm_pkg.sv]
package rqm_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] RQM_ADDR_REF01_RANGE = 8'h16;
  localparam logic [7:0] RQM_ADDR_REF2_RANGE = 8'h17;
  localparam logic [7:0] RQM_ADDR_SOAK_INHIBIT = 8'h1a;
  localparam logic [7:0] RQM_ADDR_QUALIFY_TIMES = 8'h1c;
  localparam logic [7:0] RQM_ADDR_PLL_CTRL_A = 8'h1d;
  localparam logic [7:0] RQM_ADDR_FAIL_MASK_0 = 8'h0c;
  localparam logic [7:0] RQM_ADDR_FAIL_MASK_1 = 8'h0d;
  localparam logic [7:0] RQM_ADDR_STATUS = 8'h0e;

  localparam logic [7:0] RQM_RST_REF01_RANGE = 8'h33;
  localparam logic [7:0] RQM_RST_REF2_RANGE = 8'h33;
  localparam logic [7:0] RQM_RST_SOAK_INHIBIT = 8'hff;
  localparam logic [7:0] RQM_RST_QUALIFY_TIMES = 8'h15;
  localparam logic [7:0] RQM_RST_PLL_CTRL_A = 8'h7a;
  localparam logic [7:0] RQM_RST_FAIL_MASK = 8'hff;

  // Writable bits; reserved bits hold their reset value
  localparam logic [7:0] RQM_WMASK_REF01 = 8'h77;
  localparam logic [7:0] RQM_WMASK_REF2 = 8'h07;
  localparam logic [7:0] RQM_WMASK_INHIBIT = 8'h3f;
  localparam logic [7:0] RQM_WMASK_QUALIFY = 8'h3f;
  localparam logic [7:0] RQM_WMASK_PLL = 8'h3f;
  localparam logic [7:0] RQM_WMASK_MASK0 = 8'hff;
  localparam logic [7:0] RQM_WMASK_MASK1 = 8'h0f;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RQM_RANGE_A_LSB = 0;
  localparam int RQM_RANGE_B_LSB = 4;
  localparam int RQM_RANGE_C_LSB = 0;
  localparam int RQM_DROP_LSB = 0;
  localparam int RQM_ACCEPT_LSB = 4;
  localparam int RQM_REALIGN_BIT = 0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint RQM_CLK_HZ = 40000000;
  localparam longint RQM_TICK_US = 500;
  localparam longint RQM_TICK_CYCLES = RQM_CLK_HZ * RQM_TICK_US / 1000000;

  // Window upper bound in tenths of a ppm
  function automatic logic [10:0] rqm_range_tenth_ppm(input logic [2:0] c);
    case (c)
      3'h0: rqm_range_tenth_ppm = 11'd120;
      3'h1: rqm_range_tenth_ppm = 11'd520;
      3'h2: rqm_range_tenth_ppm = 11'd1300;
      3'h3: rqm_range_tenth_ppm = 11'd830;
      3'h4: rqm_range_tenth_ppm = 11'd180;
      3'h5: rqm_range_tenth_ppm = 11'd320;
      3'h6: rqm_range_tenth_ppm = 11'd475;
      default: rqm_range_tenth_ppm = 11'd675;
    endcase
  endfunction

  // Drop delay in 0.5 ms ticks; code 0 is the minimum, one tick
  function automatic logic [17:0] rqm_drop_ticks(input logic [3:0] c);
    case (c)
      4'h0: rqm_drop_ticks = 18'd1;
      4'h1: rqm_drop_ticks = 18'd1;
      4'h2: rqm_drop_ticks = 18'd2;
      4'h3: rqm_drop_ticks = 18'd10;
      4'h4: rqm_drop_ticks = 18'd20;
      4'h5: rqm_drop_ticks = 18'd100;
      4'h6: rqm_drop_ticks = 18'd200;
      4'h7: rqm_drop_ticks = 18'd1000;
      4'h8: rqm_drop_ticks = 18'd2000;
      4'h9: rqm_drop_ticks = 18'd4000;
      4'ha: rqm_drop_ticks = 18'd5000;
      4'hb: rqm_drop_ticks = 18'd8000;
      4'hc: rqm_drop_ticks = 18'd16000;
      4'hd: rqm_drop_ticks = 18'd32000;
      4'he: rqm_drop_ticks = 18'd64000;
      default: rqm_drop_ticks = 18'd128000;
    endcase
  endfunction

  function automatic logic [5:0] rqm_accept_mult(input logic [1:0] c);
    case (c)
      2'h0: rqm_accept_mult = 6'd2;
      2'h1: rqm_accept_mult = 6'd4;
      2'h2: rqm_accept_mult = 6'd16;
      default: rqm_accept_mult = 6'd32;
    endcase
  endfunction

  typedef enum logic [0:0] {
    RQM_QUALIFIED = 1'b0,
    RQM_DISQUALIFIED = 1'b1
  } rqm_qual_type;
endpackage

// [verilog/rqm_ref_qual.sv]
`timescale 1ns/1ps
module rqm_ref_qual #(
  parameter int NUM_REFS = 3,
  parameter longint TICK_CYCLES = rqm_pkg::RQM_TICK_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [2:0] single_cycle_check_in,
  input wire logic [2:0] coarse_freq_check_in,
  input wire logic [2:0] precise_freq_check_in,
  input wire logic ref_switch_in,
  output logic [7:0] reg_rdata_out,
  output logic [2:0] ref_disq_out,
  output logic [32:0] range_limit_out,
  output logic phase_realign_select_out,
  output logic phase_buildout_out,
  output logic phase_realign_out,
  output logic irq_out
);
  import rqm_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] ref01_reg, ref01_next;
  logic [7:0] ref2_reg, ref2_next;
  logic [7:0] inhibit_reg, inhibit_next;
  logic [7:0] qualify_reg, qualify_next;
  logic [7:0] pll_reg, pll_next;
  logic [7:0] mask0_reg, mask0_next;
  logic [7:0] mask1_reg, mask1_next;
  logic [7:0] rdata_reg, rdata_next;

  function automatic logic [7:0] rqm_merge(input logic [7:0] old,
                                           input logic [7:0] wd,
                                           input logic [7:0] wm);
    rqm_merge = (old & ~wm) | (wd & wm);
  endfunction

  always_comb begin
    ref01_next = ref01_reg;
    ref2_next = ref2_reg;
    inhibit_next = inhibit_reg;
    qualify_next = qualify_reg;
    pll_next = pll_reg;
    mask0_next = mask0_reg;
    mask1_next = mask1_reg;
    rdata_next = rdata_reg;
    if (reg_wr_in) begin
      case (reg_addr_in)
        RQM_ADDR_REF01_RANGE:
          ref01_next = rqm_merge(ref01_reg, reg_wdata_in, RQM_WMASK_REF01);
        RQM_ADDR_REF2_RANGE:
          ref2_next = rqm_merge(ref2_reg, reg_wdata_in, RQM_WMASK_REF2);
        RQM_ADDR_SOAK_INHIBIT:
          inhibit_next = rqm_merge(inhibit_reg, reg_wdata_in,
                                   RQM_WMASK_INHIBIT);
        RQM_ADDR_QUALIFY_TIMES:
          qualify_next = rqm_merge(qualify_reg, reg_wdata_in,
                                   RQM_WMASK_QUALIFY);
        RQM_ADDR_PLL_CTRL_A:
          pll_next = rqm_merge(pll_reg, reg_wdata_in, RQM_WMASK_PLL);
        RQM_ADDR_FAIL_MASK_0:
          mask0_next = rqm_merge(mask0_reg, reg_wdata_in, RQM_WMASK_MASK0);
        RQM_ADDR_FAIL_MASK_1:
          mask1_next = rqm_merge(mask1_reg, reg_wdata_in, RQM_WMASK_MASK1);
        default: begin
        end
      endcase
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        RQM_ADDR_REF01_RANGE: rdata_next = ref01_reg;
        RQM_ADDR_REF2_RANGE: rdata_next = ref2_reg;
        RQM_ADDR_SOAK_INHIBIT: rdata_next = inhibit_reg;
        RQM_ADDR_QUALIFY_TIMES: rdata_next = qualify_reg;
        RQM_ADDR_PLL_CTRL_A: rdata_next = pll_reg;
        RQM_ADDR_FAIL_MASK_0: rdata_next = mask0_reg;
        RQM_ADDR_FAIL_MASK_1: rdata_next = mask1_reg;
        RQM_ADDR_STATUS: rdata_next = {5'h0, ref_disq_out};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ref01_reg <= RQM_RST_REF01_RANGE;
      ref2_reg <= RQM_RST_REF2_RANGE;
      inhibit_reg <= RQM_RST_SOAK_INHIBIT;
      qualify_reg <= RQM_RST_QUALIFY_TIMES;
      pll_reg <= RQM_RST_PLL_CTRL_A & ~8'h01;
      mask0_reg <= RQM_RST_FAIL_MASK;
      mask1_reg <= RQM_RST_FAIL_MASK;
      rdata_reg <= 8'h00;
    end else begin
      ref01_reg <= ref01_next;
      ref2_reg <= ref2_next;
      inhibit_reg <= inhibit_next;
      qualify_reg <= qualify_next;
      pll_reg <= pll_next;
      mask0_reg <= mask0_next;
      mask1_reg <= mask1_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Soak timers
  // ----------------------------------------------------------------
  logic [2:0] ref_a_range_code, ref_b_range_code, ref_c_range_code;
  logic [3:0] drop_delay_code;
  logic [1:0] accept_multiplier_code;
  logic [17:0] drop_ticks;
  logic [5:0] accept_mult;
  logic [15:0] tick_cnt_reg, tick_cnt_next;
  logic tick;
  logic [2:0] soak_fail;
  logic [2:0] disq;
  logic [1:0] ref_soak_inhibit [3];

  assign ref_a_range_code = ref01_reg[RQM_RANGE_A_LSB +: 3];
  assign ref_b_range_code = ref01_reg[RQM_RANGE_B_LSB +: 3];
  assign ref_c_range_code = ref2_reg[RQM_RANGE_C_LSB +: 3];
  assign drop_delay_code = qualify_reg[RQM_DROP_LSB +: 4];
  assign accept_multiplier_code = qualify_reg[RQM_ACCEPT_LSB +: 2];
  assign drop_ticks = rqm_drop_ticks(drop_delay_code);
  assign accept_mult = rqm_accept_mult(accept_multiplier_code);
  assign tick = (tick_cnt_reg == 16'(TICK_CYCLES - 1));

  always_comb begin
    tick_cnt_next = tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tick_cnt_reg <= 16'h0000;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_REFS; g++) begin : g_ref
      assign ref_soak_inhibit[g] = inhibit_reg[2*g +: 2];
      assign soak_fail[g] =
        (single_cycle_check_in[g] && ref_soak_inhibit[g][0]) ||
        (coarse_freq_check_in[g] && ref_soak_inhibit[g][1]);
      rqm_soak_timer u_soak (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .tick_in(tick),
        .fail_in(soak_fail[g]),
        .drop_ticks_in(drop_ticks),
        .accept_mult_in(accept_mult),
        .disq_out(disq[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Outputs and interrupt
  // ----------------------------------------------------------------
  logic [11:0] fail_vec;
  logic [11:0] mask_vec;
  logic irq_next, buildout_next, realign_next;
  logic [32:0] range_next;

  assign mask_vec = {mask1_reg[3:0], mask0_reg};
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      fail_vec[4*i +: 4] = {precise_freq_check_in[i], disq[i],
                            coarse_freq_check_in[i], single_cycle_check_in[i]};
    end
    irq_next = |(fail_vec & mask_vec);
    buildout_next = ref_switch_in && !pll_reg[RQM_REALIGN_BIT];
    realign_next = ref_switch_in && pll_reg[RQM_REALIGN_BIT];
    range_next = {rqm_range_tenth_ppm(ref_c_range_code),
                  rqm_range_tenth_ppm(ref_b_range_code),
                  rqm_range_tenth_ppm(ref_a_range_code)};
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_out <= 1'b0;
      phase_buildout_out <= 1'b0;
      phase_realign_out <= 1'b0;
      phase_realign_select_out <= 1'b0;
      ref_disq_out <= 3'h0;
      range_limit_out <= 33'h0;
    end else begin
      irq_out <= irq_next;
      phase_buildout_out <= buildout_next;
      phase_realign_out <= realign_next;
      phase_realign_select_out <= pll_reg[RQM_REALIGN_BIT];
      ref_disq_out <= disq;
      range_limit_out <= range_next;
    end
  end

  assign reg_rdata_out = rdata_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_buildout;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      (ref_switch_in && !pll_reg[RQM_REALIGN_BIT])
        |=> phase_buildout_out && !phase_realign_out;
  endproperty
  a_buildout: assert property (p_buildout)
    else $error("no build-out");

  property p_realign;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      (ref_switch_in && pll_reg[RQM_REALIGN_BIT])
        |=> phase_realign_out && !phase_buildout_out;
  endproperty
  a_realign: assert property (p_realign)
    else $error("no realign");

  property p_irq;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      (|(fail_vec & mask_vec)) |=> irq_out;
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq missed");

  property p_irq_masked;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      (mask_vec == 12'h0) |=> !irq_out;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("masked irq");

  property p_inhibit;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      (!inhibit_reg[0] && !coarse_freq_check_in[0]) |-> !soak_fail[0];
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("inhibit ignored");

  property p_single_soak;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      (single_cycle_check_in[1] && inhibit_reg[2]) |-> soak_fail[1];
  endproperty
  a_single_soak: assert property (p_single_soak)
    else $error("soak not fed");

  property p_range;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      (ref01_reg[2:0] == 3'h2) |=> range_limit_out[10:0] == 11'd1300;
  endproperty
  a_range: assert property (p_range)
    else $error("bad range");

  property p_range_hi;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      (ref2_reg[2:0] == 3'h7) |=> range_limit_out[32:22] == 11'd675;
  endproperty
  a_range_hi: assert property (p_range_hi)
    else $error("bad range c");

  property p_drop;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      (qualify_reg[3:0] == 4'h6) |-> drop_ticks == 18'd200;
  endproperty
  a_drop: assert property (p_drop)
    else $error("bad drop");
endmodule // rqm_ref_qual

// [verilog/rqm_soak_timer.sv]
`timescale 1ns/1ps
module rqm_soak_timer (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic tick_in,
  input wire logic fail_in,
  input wire logic [17:0] drop_ticks_in,
  input wire logic [5:0] accept_mult_in,
  output logic disq_out
);
  import rqm_pkg::*;

  rqm_qual_type state_reg, state_next;
  logic [23:0] cnt_reg, cnt_next;
  logic [23:0] accept_ticks;

  assign accept_ticks = drop_ticks_in * accept_mult_in;

  // Leaky count while qualified: rises while failing, falls while clean,
  // so short glitches average out instead of disqualifying at once
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    if (tick_in) begin
      case (state_reg)
        RQM_QUALIFIED: begin
          if (fail_in) begin
            cnt_next = cnt_reg + 24'd1;
          end else if (cnt_reg != 24'd0) begin
            cnt_next = cnt_reg - 24'd1;
          end
          if (fail_in && (cnt_reg + 24'd1 >= {6'h0, drop_ticks_in})) begin
            state_next = RQM_DISQUALIFIED;
            cnt_next = 24'd0;
          end
        end
        RQM_DISQUALIFIED: begin
          if (fail_in) begin
            cnt_next = 24'd0;
          end else begin
            cnt_next = cnt_reg + 24'd1;
          end
          if (!fail_in && (cnt_reg + 24'd1 >= accept_ticks)) begin
            state_next = RQM_QUALIFIED;
            cnt_next = 24'd0;
          end
        end
        default: begin
          state_next = RQM_QUALIFIED;
          cnt_next = 24'd0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg <= RQM_QUALIFIED;
      cnt_reg <= 24'd0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  assign disq_out = (state_reg == RQM_DISQUALIFIED);
endmodule // rqm_soak_timer
